//--- hw/eeprom_wr_map.svh
// offsets, field positions, reset values and timing counts of the eeprom write-access block
`ifndef EEPROM_WR_MAP_SVH
`define EEPROM_WR_MAP_SVH
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define CTRL_PROTECT_BIT 0
`define STATUS_BUSY_BIT 0
`define STATUS_HALF_BIT 1
`define STATUS_RPTR_LSB 8
`define CTRL_RESET 1'b0
`define SLAVE_ID_NIBBLE 4'hA
`define DIRCTL_ADDR 8'h7A
`define PIO_ADDRESSING_SELECT_BIT_BIT 0
`define PIO_ADDRESSING_SELECT_BIT_SINGLE 1'b1
`define PIO_BASE 8'h7C
`define SRAM_WRAP_ADDR 8'h7A
`define SRAM_END_ADDR 8'h7F
`define SRAM_NOACK_A 8'h78
`define SRAM_NOACK_B 8'h79
`define SPECIAL_PROT_ADDR 8'h6E
`define SHORT_BLOCK_NIB 4'h7
`define SPECIAL_BLOCK_NIB 4'h6
`define RESERVED_BLOCK_NIB 4'hF
`define CLK_PERIOD_NS 10
`define EEPROM_PROGRAM_TIME_US 5000
`endif

//--- hw/eeprom_wr_pkg.sv
// types shared by the eeprom write-access block
package eeprom_wr_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_DEV, ST_DEV_ACK, ST_MADDR, ST_MADDR_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_SKIP
   } i2c_state_t;
   typedef enum logic [2:0] {
      RG_NORMAL, RG_SHORT, RG_SPECIAL, RG_RESERVED, RG_SRAM, RG_PIO
   } region_t;
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
      logic [31:0] hwdata;
   } ahb_req_t;
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } ahb_rsp_t;
   typedef struct packed {
      logic scl;
      logic sda;
      logic wp;
      logic bus_select_pin_low;
      logic bus_select_pin_high;
   } pin_in_t;
   typedef struct packed {
      logic sda_o;
      logic sda_oe;
   } pin_out_t;
endpackage

//--- hw/eeprom_sram_write_access.sv
// two-wire slave memory with eeprom staging buffer, pio/sram pointer logic and ahb-lite status port
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`include "eeprom_wr_map.svh"

module eeprom_sram_write_access
   import eeprom_wr_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = (`EEPROM_PROGRAM_TIME_US * 1000) / `CLK_PERIOD_NS
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire ahb_req_t ahb_req,
   output ahb_rsp_t ahb_rsp,
   // device pins
   input wire pin_in_t pins,
   output pin_out_t pins_out
);

   typedef struct packed {
      logic [4:0] pin_s1;
      logic [4:0] pin_s2;
      logic scl_s3;
      logic sda_s3;
      i2c_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic sda_oe;
      logic rw;
      logic half;
      logic ack;
      region_t region;
      logic [7:0] wptr;
      logic [8:0] rptr;
      logic [15:0][7:0] buffer;
      logic dirty;
      logic busy;
      logic [23:0] prog_cnt;
      logic [4:0] prog_blk;
      logic protect_mode;
      logic a_sel;
      logic a_write;
      logic [7:0] a_addr;
      logic [31:0] hrdata;
      logic [511:0][7:0] mem;
   } state_t;

   localparam logic [23:0] PROG_LAST = 24'(PROG_CYCLES - 1);

   // synchroniser stages start at the idle bus level, so release of reset shows no false scl or sda edge
   localparam state_t S_RESET = '{
      pin_s1: 5'h18,
      pin_s2: 5'h18,
      scl_s3: 1'b1,
      sda_s3: 1'b1,
      st: ST_IDLE,
      bitcnt: 4'h0,
      shreg: 8'h00,
      sda_oe: 1'b0,
      rw: 1'b0,
      half: 1'b0,
      ack: 1'b0,
      region: RG_NORMAL,
      wptr: 8'h00,
      rptr: 9'h000,
      buffer: '0,
      dirty: 1'b0,
      busy: 1'b0,
      prog_cnt: 24'h000000,
      prog_blk: 5'h00,
      protect_mode: `CTRL_RESET,
      a_sel: 1'b0,
      a_write: 1'b0,
      a_addr: 8'h00,
      hrdata: 32'h0000_0000,
      mem: '0
   };

   state_t s_q;
   state_t s_d;

   function automatic region_t classify(input logic half, input logic [7:0] a, input logic single);
      region_t r;
      r = RG_NORMAL;
      if (!half && a[7:4] == `SHORT_BLOCK_NIB)
      begin
         if (!a[3])
            r = RG_SHORT;
         else if (single)
            r = (a == `PIO_BASE) ? RG_PIO : RG_SRAM;
         else
            r = (a >= `PIO_BASE) ? RG_PIO : RG_SRAM;
      end
      else if (half && a[7:4] == `SPECIAL_BLOCK_NIB)
         r = RG_SPECIAL;
      else if (half && a[7:4] == `RESERVED_BLOCK_NIB)
         r = RG_RESERVED;
      return r;
   endfunction

   function automatic logic data_ack(input region_t r, input logic [7:0] a, input logic wp, input logic prot,
                                     input logic single);
      logic ok;
      ok = 1'b0;
      unique case (r)
         RG_NORMAL, RG_SHORT: ok = !wp;
         RG_SPECIAL: ok = !wp && !(prot && a == `SPECIAL_PROT_ADDR);
         RG_RESERVED: ok = 1'b0;
         RG_SRAM:
         begin
            ok = !(a == `SRAM_NOACK_A || a == `SRAM_NOACK_B);
            if (single && a > `PIO_BASE)
               ok = 1'b0;
         end
         RG_PIO: ok = 1'b1;
      endcase
      return ok;
   endfunction

   function automatic logic [7:0] next_ptr(input region_t r, input logic [7:0] a, input logic single);
      logic [7:0] n;
      n = a;
      unique case (r)
         RG_NORMAL, RG_SPECIAL, RG_RESERVED: n = {a[7:4], 4'(a[3:0] + 4'h1)};
         RG_SHORT: n = {a[7:3], 3'(a[2:0] + 3'h1)};
         RG_SRAM: n = (a == `SRAM_END_ADDR) ? `SRAM_WRAP_ADDR : 8'(a + 8'h01);
         RG_PIO:
         begin
            if (single)
               n = `PIO_BASE;
            else
               n = (a == `SRAM_END_ADDR) ? `PIO_BASE : 8'(a + 8'h01);
         end
      endcase
      return n;
   endfunction

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic wp_pin;
   logic single_mode;
   logic dev_match;
   logic is_eeprom;

   always_comb
   begin
      s_d = s_q;
      // two flip-flops on every pin before any logic looks at it
      s_d.pin_s1 = pins;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.scl_s3 = s_q.pin_s2[4];
      s_d.sda_s3 = s_q.pin_s2[3];
      scl_rise = s_q.pin_s2[4] && !s_q.scl_s3;
      scl_fall = !s_q.pin_s2[4] && s_q.scl_s3;
      start_cond = s_q.pin_s2[4] && s_q.scl_s3 && s_q.sda_s3 && !s_q.pin_s2[3];
      stop_cond = s_q.pin_s2[4] && s_q.scl_s3 && !s_q.sda_s3 && s_q.pin_s2[3];
      wp_pin = s_q.pin_s2[2];
      single_mode = (s_q.mem[{1'b0, `DIRCTL_ADDR}][`PIO_ADDRESSING_SELECT_BIT_BIT] == `PIO_ADDRESSING_SELECT_BIT_SINGLE);
      dev_match = (s_q.shreg[7:4] == `SLAVE_ID_NIBBLE) && (s_q.shreg[3] == s_q.pin_s2[0])
                  && (s_q.shreg[2] == s_q.pin_s2[1]);
      is_eeprom = (s_q.region == RG_NORMAL) || (s_q.region == RG_SHORT) || (s_q.region == RG_SPECIAL)
                  || (s_q.region == RG_RESERVED);

      // program cycle: the staged block lands in the array when the time has run out
      if (s_q.busy)
      begin
         s_d.prog_cnt = 24'(s_q.prog_cnt + 24'h1);
         if (s_q.prog_cnt >= PROG_LAST)
         begin
            s_d.busy = 1'b0;
            for (int i = 0; i < 16; i++)
               s_d.mem[{s_q.prog_blk, 4'(i)}] = s_q.buffer[i];
         end
      end

      if (start_cond)
      begin
         s_d.st = ST_DEV;
         s_d.bitcnt = 4'h0;
         s_d.sda_oe = 1'b0;
      end
      else if (stop_cond)
      begin
         s_d.st = ST_IDLE;
         s_d.sda_oe = 1'b0;
         if (s_q.dirty && !s_q.busy)
         begin
            // only acknowledged eeprom bytes set dirty, so write-protect blocks the cycle too
            s_d.busy = 1'b1;
            s_d.prog_cnt = 24'h0;
            s_d.dirty = 1'b0;
         end
      end
      else
      begin
         unique case (s_q.st)
            ST_IDLE, ST_SKIP:
            begin
               s_d.sda_oe = 1'b0;
            end
            ST_DEV, ST_MADDR, ST_WDATA:
            begin
               if (scl_rise && s_q.bitcnt < 4'h8)
               begin
                  s_d.shreg = {s_q.shreg[6:0], s_q.pin_s2[3]};
                  s_d.bitcnt = 4'(s_q.bitcnt + 4'h1);
               end
               else if (scl_fall && s_q.bitcnt == 4'h8)
               begin
                  s_d.bitcnt = 4'h0;
                  if (s_q.st == ST_DEV)
                  begin
                     // busy device refuses its address until the array is written
                     s_d.ack = dev_match && !s_q.busy;
                     s_d.rw = s_q.shreg[0];
                     if (!s_q.shreg[0])
                        s_d.half = s_q.shreg[1];
                     s_d.st = ST_DEV_ACK;
                  end
                  else if (s_q.st == ST_MADDR)
                  begin
                     s_d.ack = 1'b1;
                     s_d.wptr = s_q.shreg;
                     s_d.rptr = {s_q.half, s_q.shreg};
                     s_d.region = classify(s_q.half, s_q.shreg, single_mode);
                     s_d.dirty = 1'b0;
                     for (int i = 0; i < 16; i++)
                        s_d.buffer[i] = s_q.mem[{s_q.half, s_q.shreg[7:4], 4'(i)}];
                     s_d.prog_blk = {s_q.half, s_q.shreg[7:4]};
                     s_d.st = ST_MADDR_ACK;
                  end
                  else
                  begin
                     s_d.ack = data_ack(s_q.region, s_q.wptr, wp_pin, s_q.protect_mode, single_mode);
                     if (s_d.ack)
                     begin
                        if (is_eeprom)
                        begin
                           s_d.buffer[s_q.wptr[3:0]] = s_q.shreg;
                           s_d.dirty = 1'b1;
                        end
                        else
                           s_d.mem[{s_q.half, s_q.wptr}] = s_q.shreg;
                     end
                     // a refused byte still moves the pointers but stores nothing
                     s_d.wptr = next_ptr(s_q.region, s_q.wptr, single_mode);
                     s_d.rptr = {s_q.half, s_d.wptr};
                     s_d.st = ST_WDATA_ACK;
                  end
                  s_d.sda_oe = s_d.ack;
               end
            end
            ST_DEV_ACK:
            begin
               if (scl_fall)
               begin
                  s_d.sda_oe = 1'b0;
                  if (!s_q.ack)
                     s_d.st = ST_SKIP;
                  else if (s_q.rw)
                  begin
                     s_d.shreg = {s_q.mem[s_q.rptr][6:0], 1'b0};
                     s_d.sda_oe = !s_q.mem[s_q.rptr][7];
                     s_d.rptr = {s_q.rptr[8], 8'(s_q.rptr[7:0] + 8'h01)};
                     s_d.bitcnt = 4'h1;
                     s_d.st = ST_RDATA;
                  end
                  else
                     s_d.st = ST_MADDR;
               end
            end
            ST_MADDR_ACK, ST_WDATA_ACK:
            begin
               if (scl_fall)
               begin
                  s_d.sda_oe = 1'b0;
                  s_d.st = ST_WDATA;
               end
            end
            ST_RDATA:
            begin
               if (scl_fall)
               begin
                  if (s_q.bitcnt == 4'h8)
                  begin
                     s_d.sda_oe = 1'b0;
                     s_d.st = ST_RACK;
                  end
                  else
                  begin
                     s_d.sda_oe = !s_q.shreg[7];
                     s_d.shreg = {s_q.shreg[6:0], 1'b0};
                     s_d.bitcnt = 4'(s_q.bitcnt + 4'h1);
                  end
               end
            end
            ST_RACK:
            begin
               if (scl_rise)
                  s_d.ack = !s_q.pin_s2[3];
               else if (scl_fall)
               begin
                  if (s_q.ack)
                  begin
                     s_d.shreg = {s_q.mem[s_q.rptr][6:0], 1'b0};
                     s_d.sda_oe = !s_q.mem[s_q.rptr][7];
                     s_d.rptr = {s_q.rptr[8], 8'(s_q.rptr[7:0] + 8'h01)};
                     s_d.bitcnt = 4'h1;
                     s_d.st = ST_RDATA;
                  end
                  else
                     s_d.st = ST_SKIP;
               end
            end
         endcase
      end

      // ahb-lite slave: zero wait states, write data applied in the data phase
      if (s_q.a_sel && s_q.a_write && s_q.a_addr == `REG_CTRL_OFS)
         s_d.protect_mode = ahb_req.hwdata[`CTRL_PROTECT_BIT];
      if (ahb_req.hready)
      begin
         s_d.a_sel = ahb_req.hsel && ahb_req.htrans[1];
         s_d.a_write = ahb_req.hwrite;
         s_d.a_addr = ahb_req.haddr[7:0];
         if (ahb_req.hsel && ahb_req.htrans[1] && !ahb_req.hwrite)
         begin
            s_d.hrdata = 32'h0000_0000;
            if (ahb_req.haddr[7:0] == `REG_CTRL_OFS)
               s_d.hrdata[`CTRL_PROTECT_BIT] = s_q.protect_mode;
            else if (ahb_req.haddr[7:0] == `REG_STATUS_OFS)
            begin
               s_d.hrdata[`STATUS_BUSY_BIT] = s_q.busy;
               s_d.hrdata[`STATUS_HALF_BIT] = s_q.half;
               s_d.hrdata[`STATUS_RPTR_LSB +: 9] = s_q.rptr;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_q <= S_RESET;
      else
         s_q <= s_d;
   end

   assign ahb_rsp.hreadyout = 1'b1;
   assign ahb_rsp.hresp = 1'b0;
   assign ahb_rsp.hrdata = s_q.hrdata;
   assign pins_out.sda_o = 1'b0;
   assign pins_out.sda_oe = s_q.sda_oe;

endmodule

//--- testbench/eeprom_sram_write_access_asserts.sv
// port checker for the eeprom write-access block
module eeprom_sram_write_access_asserts
   import eeprom_wr_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = 600
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus and pins
   input wire ahb_req_t ahb_req,
   input wire ahb_rsp_t ahb_rsp,
   input wire pin_in_t pins,
   input wire pin_out_t pins_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rd_take;
   logic wr_ctrl_q;
   logic ctrl_q;
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   assign rd_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite;
   // shadow of the protect bit, so readback is judged against what was written
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ctrl_q <= 1'b0;
         ctrl_q <= 1'b0;
      end
      else
      begin
         wr_ctrl_q <= ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite && ahb_req.haddr == 32'h0;
         if (wr_ctrl_q)
            ctrl_q <= ahb_req.hwdata[0];
      end
   end
   AST_BUS_OKAY: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp) else $error("bus stall or error");
   AST_OE_IN_LOW: assert property ($changed(pins_out.sda_oe) |-> !pins.scl && $past(!pins.scl, 2))
      else $error("sda drive changed outside scl low");
   AST_DATA_STABLE: assert property (pins.scl && $past(pins.scl, 4) |-> $stable(pins_out.sda_oe))
      else $error("sda drive moved while scl high");
   AST_START_QUIET: assert property ($fell(pins.sda) && pins.scl |=> !pins_out.sda_oe [*4])
      else $error("sda driven right after start");
   AST_RDATA_HOLDS: assert property (!$past(rd_take) |-> $stable(ahb_rsp.hrdata))
      else $error("read data moved without a read");
   AST_STATUS_SHAPE: assert property (rd_take && ahb_req.haddr == 32'h4
      |=> ahb_rsp.hrdata[31:17] == 15'h0 && ahb_rsp.hrdata[7:2] == 6'h0) else $error("status spare bits set");
   AST_UNMAPPED_ZERO: assert property (rd_take && ahb_req.haddr >= 32'h8 |=> ahb_rsp.hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_CTRL_READBACK: assert property (rd_take && ahb_req.haddr == 32'h0 |=> ahb_rsp.hrdata == {31'h0, ctrl_q})
      else $error("protect bit readback wrong");
endmodule

bind eeprom_sram_write_access eeprom_sram_write_access_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.hclk(hclk),
   .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .pins(pins), .pins_out(pins_out));

//--- testbench/i2c_master_model.sv
// two-wire bus master that drives the far side of the block
module i2c_master_model
#(
   parameter int HALF_NS = 100
)
(
   // bus lines, sda_low pulls the wire low
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // sda only moves a half period after scl fell, clear of the sampling lag
   task automatic clk_bit(input logic b, output logic s);
      sda_low = !b;
      #(HALF_NS) scl = 1'b1;
      #(HALF_NS) s = sda;
      scl = 1'b0;
      #(HALF_NS);
   endtask
   task automatic start();
      sda_low = 1'b0;
      #(HALF_NS) scl = 1'b1;
      #(HALF_NS) sda_low = 1'b1;
      #(HALF_NS) scl = 1'b0;
      #(HALF_NS);
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #(HALF_NS) scl = 1'b1;
      #(HALF_NS) sda_low = 1'b0;
      #(HALF_NS);
   endtask
   // msb first, then the ack slot with sda released
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(b[i], s);
      clk_bit(1'b1, s);
      ack = !s;
   endtask
   task automatic recv(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(1'b1, b[i]);
      clk_bit(last, s);
   endtask
endmodule

//--- testbench/eeprom_sram_write_access_test.sv
// self-checking testbench of the eeprom write-access block
module eeprom_sram_write_access_test;
   import eeprom_wr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned PROG = 600;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic wp = 1'b0;
   logic scl;
   logic sda_low;
   logic sda_w;
   int errors = 0;
   int comparisons = 0;
   ahb_req_t req;
   ahb_rsp_t rsp;
   pin_in_t pin;
   pin_out_t pout;
   always #5 hclk = ~hclk;
   // open-drain wire with pull-up
   assign sda_w = !(sda_low || pout.sda_oe);
   assign pin = {scl, sda_w, wp, 1'b0, 1'b1};
   assign req = {hsel, haddr, htrans, hwrite, 3'h2, rsp.hreadyout, hwdata};
   eeprom_sram_write_access #(.PROG_CYCLES(PROG)) u_dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req),
      .ahb_rsp(rsp), .pins(pin), .pins_out(pout));
   i2c_master_model u_m (.scl(scl), .sda_low(sda_low), .sda(sda_w));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ack(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
      rd = rsp.hrdata;
   endtask
   task automatic chk_ptr(input logic [8:0] p, input logic busy);
      logic [31:0] s;
      ahb(1'b0, 32'h4, 32'h0, s);
      chk({22'h0, s[16:8], s[0]}, {22'h0, p, busy});
   endtask
   task automatic wait_idle();
      logic [31:0] s;
      int n = 0;
      do
      begin
         ahb(1'b0, 32'h4, 32'h0, s);
         n++;
      end
      while (s[0] !== 1'b0 && n < 1000);
      chk_ack(s[0], 1'b0);
   endtask
   task automatic wframe(input logic half, input logic [7:0] a, input int n, input logic [63:0] d,
                         input logic [7:0] acks);
      logic k;
      wait_idle();
      u_m.start();
      u_m.send({4'hA, 2'b10, half, 1'b0}, k);
      chk_ack(k, 1'b1);
      u_m.send(a, k);
      chk_ack(k, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         u_m.send(d[8*i +: 8], k);
         chk_ack(k, acks[i]);
      end
      u_m.stop();
   endtask
   // the read frame always carries half bit 0, the half of the last write must apply
   task automatic rd_at(input logic half, input logic [7:0] a, input int n, output logic [63:0] q);
      logic k;
      wframe(half, a, 0, 64'h0, 8'h0);
      wait_idle();
      q = '0;
      u_m.start();
      u_m.send(8'hA9, k);
      chk_ack(k, 1'b1);
      for (int i = 0; i < n; i++)
         u_m.recv(i == n - 1, q[8*i +: 8]);
      u_m.stop();
   endtask
   task automatic t_select();
      logic k;
      u_m.start();
      u_m.send(8'hA4, k);
      chk_ack(k, 1'b0);
      u_m.stop();
      u_m.start();
      u_m.send(8'hB8, k);
      chk_ack(k, 1'b0);
      u_m.stop();
      $display("test select done");
   endtask
   task automatic t_eeprom();
      logic [63:0] q;
      logic k;
      wframe(1'b0, 8'h11, 1, 64'h55, 8'h01);
      wframe(1'b0, 8'h1E, 3, 64'hC3B2A1, 8'h07);
      chk_ptr(9'h011, 1'b1);
      u_m.start();
      u_m.send(8'hA8, k);
      chk_ack(k, 1'b0);
      u_m.stop();
      rd_at(1'b0, 8'h1E, 2, q);
      chk(q[31:0], 32'h0000B2A1);
      rd_at(1'b0, 8'h10, 2, q);
      chk(q[31:0], 32'h000055C3);
      $display("test eeprom done");
   endtask
   task automatic t_protect();
      logic [63:0] q;
      @(posedge hclk) wp <= 1'b1;
      wframe(1'b0, 8'h30, 1, 64'hAA, 8'h00);
      chk_ptr(9'h031, 1'b0);
      @(posedge hclk) wp <= 1'b0;
      rd_at(1'b0, 8'h30, 1, q);
      chk(q[31:0], 32'h0);
      wframe(1'b0, 8'h76, 3, 64'h332211, 8'h07);
      chk_ptr(9'h071, 1'b1);
      rd_at(1'b0, 8'h70, 1, q);
      chk(q[31:0], 32'h33);
      $display("test protect done");
   endtask
   task automatic t_special();
      logic [63:0] q;
      logic [31:0] s;
      ahb(1'b1, 32'h0, 32'h1, s);
      ahb(1'b0, 32'h0, 32'h0, s);
      chk(s, 32'h1);
      ahb(1'b0, 32'h10, 32'h0, s);
      chk(s, 32'h0);
      wframe(1'b1, 8'h6E, 2, 64'h6665, 8'h02);
      ahb(1'b1, 32'h0, 32'h0, s);
      wframe(1'b1, 8'hF0, 1, 64'h77, 8'h00);
      chk_ptr(9'h1F1, 1'b0);
      rd_at(1'b1, 8'h6E, 2, q);
      chk(q[31:0], 32'h6600);
      wframe(1'b1, 8'h6E, 1, 64'h5A, 8'h01);
      rd_at(1'b1, 8'h6E, 1, q);
      chk(q[31:0], 32'h5A);
      $display("test special done");
   endtask
   task automatic t_sram();
      wframe(1'b0, 8'h78, 2, 64'h2221, 8'h00);
      chk_ptr(9'h07A, 1'b0);
      wframe(1'b0, 8'h7A, 7, 64'h00161514131200, 8'h7F);
      chk_ptr(9'h07B, 1'b0);
      wframe(1'b0, 8'h7C, 5, 64'h4544434241, 8'h1F);
      chk_ptr(9'h07D, 1'b0);
      wframe(1'b0, 8'h7A, 1, 64'h01, 8'h01);
      wframe(1'b0, 8'h7C, 3, 64'h535251, 8'h07);
      chk_ptr(9'h07C, 1'b0);
      wframe(1'b0, 8'h7D, 2, 64'h6261, 8'h00);
      chk_ptr(9'h07F, 1'b0);
      wframe(1'b0, 8'h40, 1, 64'h4C, 8'h01);
      chk_ptr(9'h041, 1'b1);
      $display("test sram done");
   endtask
   task automatic complete_run();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // the whole sequence needs well under half a millisecond
   initial
   begin
      #1000000;
      errors++;
      complete_run();
   end
   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      t_select();
      t_eeprom();
      t_protect();
      t_special();
      t_sram();
      complete_run();
   end
endmodule
